// ===== inc/e1cc_pkg.sv
// shared constants and types for the e1 common control block
package e1cc_pkg;
  // register addresses on the parallel port
  localparam logic [7:0] CC_THREE_ADDR = 8'h1B;
  localparam logic [7:0] CC_SIX_ADDR   = 8'h1D;
  localparam logic [7:0] CC_FOUR_ADDR  = 8'hA8;
  localparam logic [7:0] CC_FIVE_ADDR  = 8'hAA;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] RD_NONE   = 8'h00;
  // writable bits of common_control_three and six; their unassigned bits read as zero
  localparam logic [7:0] CC_THREE_WMASK = 8'hEF;
  localparam logic [7:0] CC_SIX_WMASK   = 8'hE7;
  // common_control_three fields
  localparam int B3_TX_ESTORE_EN = 7;
  localparam int B3_CHAN_BLK_SEL = 6;
  localparam int B3_IDLE_REG_SEL = 5;
  localparam int B3_RX_SIG_REINS = 3;
  localparam int B3_TX_SIG_REINS = 2;
  localparam int B3_TX_BPCLK_SEL = 1;
  localparam int B3_CARRIER_ALT  = 0;
  // common_control_four fields
  localparam int B4_REMOTE_LOOP  = 7;
  localparam int B4_LOCAL_LOOP   = 6;
  localparam int B4_LINE_AIS     = 5;
  // common_control_five fields
  localparam int B5_RX_ALIGN     = 6;
  localparam int B5_TX_ALIGN     = 5;
  // common_control_six fields
  localparam int B6_DISCONNECT   = 6;
  localparam int B6_TX_CLK_SRC   = 2;
  localparam int B6_RX_ES_RESET  = 1;
  localparam int B6_TX_ES_RESET  = 0;
  // channel select field
  localparam int CHAN_W = 5;
  localparam int CHAN_MSB = 4;
  // carrier loss zero-run thresholds
  localparam logic [11:0] ZEROS_STD = 12'h0FF;
  localparam logic [11:0] ZEROS_ALT = 12'h800;
  // timing
  localparam int unsigned CLK_KHZ     = 250000;
  localparam int unsigned RAI_MF_MS   = 128;
  localparam int unsigned CONST_RAI_MS = 400;
  localparam int unsigned RAI_MF_CYC   = RAI_MF_MS * CLK_KHZ;
  localparam int unsigned CONST_RAI_CYC = CONST_RAI_MS * CLK_KHZ;
  // crc4 multiframe search tracker
  typedef enum logic [3:0] {
    CRC_IDLE = 4'h1,
    CRC_WAIT = 4'h2,
    CRC_LATE = 4'h4,
    CRC_HOLD = 4'h8
  } e1cc_crc_st_e;
endpackage : e1cc_pkg

// ===== inc/e1cc_strm_if.sv
// valid/ready carrier for line words between internal modules
`timescale 1ns/100ps
interface e1cc_strm_if #(parameter int W = 2);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : e1cc_strm_if

// ===== rtl/e1cc_skid2.sv
// two-entry registered buffer in the transmit line path
`timescale 1ns/100ps
module e1cc_skid2 (
  input  wire logic sys_clk,
  input  wire logic nrst,
  e1cc_strm_if.snk  in_s,
  e1cc_strm_if.src  out_s
);
  logic                       out_vld_ff;
  logic                       skid_vld_ff;
  logic [$bits(in_s.data)-1:0] out_dat_ff;
  logic [$bits(in_s.data)-1:0] skid_dat_ff;
  wire                        push = in_s.valid & ~skid_vld_ff;
  wire                        pop  = out_vld_ff & out_s.ready;

  // ready falls only when the spare slot is occupied
  assign in_s.ready  = ~skid_vld_ff;
  assign out_s.valid = out_vld_ff;
  assign out_s.data  = out_dat_ff;

  // head refills from spare first, then from input
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_vld_ff  <= 1'b0;
      skid_vld_ff <= 1'b0;
      out_dat_ff  <= '0;
      skid_dat_ff <= '0;
    end else if (!out_vld_ff || pop) begin
      out_dat_ff  <= skid_vld_ff ? skid_dat_ff : in_s.data;
      out_vld_ff  <= skid_vld_ff | push;
      skid_vld_ff <= 1'b0;
    end else if (push) begin
      skid_dat_ff <= in_s.data;
      skid_vld_ff <= 1'b1;
    end
  end

  a_skid_no_drop: assert property (@(posedge sys_clk) disable iff (!nrst)
    (out_vld_ff && !out_s.ready && push) |=> skid_vld_ff && out_vld_ff)
    else $error("buffer lost a word under stall");
endmodule : e1cc_skid2

// ===== rtl/e1cc_crc_timer.sv
// times the crc4 multiframe search after fas sync
`timescale 1ns/100ps
module e1cc_crc_timer #(
  parameter int unsigned LATE_CYC  = e1cc_pkg::RAI_MF_CYC,
  parameter int unsigned CONST_CYC = e1cc_pkg::CONST_RAI_CYC,
  localparam int         CNT_W     = $clog2(CONST_CYC + 1)
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic searching,
  output logic      late_ff,
  output logic      const_ff
);
  e1cc_pkg::e1cc_crc_st_e st_ff;
  e1cc_pkg::e1cc_crc_st_e nxt_st;
  logic [CNT_W-1:0]       cnt_ff;
  wire                    hit_late  = (cnt_ff == CNT_W'(LATE_CYC - 1));
  wire                    hit_const = (cnt_ff == CNT_W'(CONST_CYC - 1));

  // search state steps
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      e1cc_pkg::CRC_IDLE: if (searching) nxt_st = e1cc_pkg::CRC_WAIT;
      e1cc_pkg::CRC_WAIT: begin
        if (!searching) nxt_st = e1cc_pkg::CRC_IDLE;
        else if (hit_late) nxt_st = e1cc_pkg::CRC_LATE;
      end
      e1cc_pkg::CRC_LATE: begin
        if (!searching) nxt_st = e1cc_pkg::CRC_IDLE;
        else if (hit_const) nxt_st = e1cc_pkg::CRC_HOLD;
      end
      e1cc_pkg::CRC_HOLD: if (!searching) nxt_st = e1cc_pkg::CRC_IDLE;
      default: nxt_st = e1cc_pkg::CRC_IDLE;
    endcase
  end

  // elapsed search time and flags
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff    <= e1cc_pkg::CRC_IDLE;
      cnt_ff   <= '0;
      late_ff  <= 1'b0;
      const_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= (nxt_st == e1cc_pkg::CRC_IDLE) ? '0 : cnt_ff + 1'b1;
      late_ff  <= (nxt_st == e1cc_pkg::CRC_LATE) || (nxt_st == e1cc_pkg::CRC_HOLD);
      const_ff <= (nxt_st == e1cc_pkg::CRC_HOLD);
    end
  end
endmodule : e1cc_crc_timer

// ===== rtl/e1cc_common_ctrl.sv
// e1 common control: registers, automatic alarms, loopbacks, line patterns
`timescale 1ns/100ps
module e1cc_common_ctrl #(
  parameter int unsigned RAI_WAIT_CYC  = e1cc_pkg::RAI_MF_CYC,
  parameter int unsigned CONST_RAI_CYC = e1cc_pkg::CONST_RAI_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  input  wire logic       auto_ais_en,
  input  wire logic       auto_rai_en,
  input  wire logic       crc4_en,
  input  wire logic       rx_loss_sync,
  input  wire logic       rx_ais_detect,
  input  wire logic       fas_sync,
  input  wire logic       crc4_mf_sync,
  input  wire logic       tx_clock_fail_mux,
  input  wire logic       tx_clock_stopped,
  input  wire logic       tx_fmt_valid,
  input  wire logic       tx_fmt_pos,
  input  wire logic       tx_fmt_neg,
  output logic            tx_fmt_ready,
  input  wire logic       rx_line_valid,
  input  wire logic       rx_line_pos_in,
  input  wire logic       rx_line_neg_in,
  output logic            tx_line_valid,
  input  wire logic       tx_line_ready,
  output logic            tx_line_pos_out,
  output logic            tx_line_neg_out,
  output logic            rx_fr_valid,
  output logic            rx_fr_pos,
  output logic            rx_fr_neg,
  output logic            rx_carrier_loss,
  output logic            tx_ais_active,
  output logic            tx_rai_active,
  output logic            tx_rai_constant,
  output logic            tx_estore_enable,
  output logic            chan_block_func_sel,
  output logic            idle_reg_func_sel,
  output logic            rx_sig_reinsert_en,
  output logic            tx_sig_reinsert_en,
  output logic            tx_backplane_clk_sel,
  output logic            tx_clk_use_recovered,
  output logic            rx_estore_align,
  output logic            tx_estore_align,
  output logic            rx_estore_reset,
  output logic            tx_estore_reset,
  input  wire logic       tx_ts_valid,
  input  wire logic [4:0] tx_ts_num,
  input  wire logic [7:0] tx_ts_data,
  input  wire logic       rx_ts_valid,
  input  wire logic [4:0] rx_ts_num,
  input  wire logic [7:0] rx_ts_data,
  output logic      [7:0] tx_chan_monitor_reg,
  output logic      [7:0] rx_chan_monitor_reg
);
  localparam int DLY_ONE = 1;

  logic [7:0]  cc_three_ff, cc_four_ff, cc_five_ff, cc_six_ff;
  logic [7:0]  rdata_ff;
  logic        ais_ff, rai_ff, clk_rec_ff;
  logic        rx_align_ff, tx_align_ff, rx_rst_ff, tx_rst_ff;
  logic        fr_vld_ff, fr_pos_ff, fr_neg_ff, rcl_ff;
  logic [11:0] zero_cnt_ff;
  logic [1:0]  gen_cnt_ff;
  logic [7:0]  tx_mon_ff, rx_mon_ff;
  logic        late_w, const_w;

  e1cc_strm_if #(.W(2)) buf_in ();
  e1cc_strm_if #(.W(2)) buf_out ();

  // true when a timeslot beat carries the selected channel
  function automatic logic chan_hit(input logic vld, input logic [4:0] num,
                                    input logic [4:0] sel);
    chan_hit = vld && (num == sel);
  endfunction : chan_hit

  // register write decode
  wire wr3 = cpu_wr && (cpu_addr == e1cc_pkg::CC_THREE_ADDR);
  wire wr4 = cpu_wr && (cpu_addr == e1cc_pkg::CC_FOUR_ADDR);
  wire wr5 = cpu_wr && (cpu_addr == e1cc_pkg::CC_FIVE_ADDR);
  wire wr6 = cpu_wr && (cpu_addr == e1cc_pkg::CC_SIX_ADDR);

  // read selection, unmapped addresses read zero
  wire [7:0] rd_mux =
    (cpu_addr == e1cc_pkg::CC_THREE_ADDR) ? cc_three_ff :
    (cpu_addr == e1cc_pkg::CC_FOUR_ADDR)  ? cc_four_ff :
    (cpu_addr == e1cc_pkg::CC_FIVE_ADDR)  ? cc_five_ff :
    (cpu_addr == e1cc_pkg::CC_SIX_ADDR)   ? cc_six_ff : e1cc_pkg::RD_NONE;

  // command edges: only a write turning the bit from 0 to 1 fires
  wire nxt_rx_align = wr5 && cpu_wdata[e1cc_pkg::B5_RX_ALIGN]
                      && !cc_five_ff[e1cc_pkg::B5_RX_ALIGN];
  wire nxt_tx_align = wr5 && cpu_wdata[e1cc_pkg::B5_TX_ALIGN]
                      && !cc_five_ff[e1cc_pkg::B5_TX_ALIGN];
  wire nxt_rx_rst   = wr6 && cpu_wdata[e1cc_pkg::B6_RX_ES_RESET]
                      && !cc_six_ff[e1cc_pkg::B6_RX_ES_RESET];
  wire nxt_tx_rst   = wr6 && cpu_wdata[e1cc_pkg::B6_TX_ES_RESET]
                      && !cc_six_ff[e1cc_pkg::B6_TX_ES_RESET];

  // control register file and read port
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cc_three_ff <= e1cc_pkg::REG_RST;
      cc_four_ff  <= e1cc_pkg::REG_RST;
      cc_five_ff  <= e1cc_pkg::REG_RST;
      cc_six_ff   <= e1cc_pkg::REG_RST;
      rdata_ff <= e1cc_pkg::RD_NONE;
    end else begin
      if (wr3) cc_three_ff <= cpu_wdata & e1cc_pkg::CC_THREE_WMASK;
      if (wr4) cc_four_ff <= cpu_wdata;
      if (wr5) cc_five_ff <= cpu_wdata;
      if (wr6) cc_six_ff <= cpu_wdata & e1cc_pkg::CC_SIX_WMASK;
      if (cpu_rd) rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_align_ff <= 1'b0;
      tx_align_ff <= 1'b0;
      rx_rst_ff   <= 1'b0;
      tx_rst_ff   <= 1'b0;
    end else begin
      rx_align_ff <= nxt_rx_align;
      tx_align_ff <= nxt_tx_align;
      rx_rst_ff   <= nxt_rx_rst;
      tx_rst_ff   <= nxt_tx_rst;
    end
  end

  assign tx_estore_enable     = cc_three_ff[e1cc_pkg::B3_TX_ESTORE_EN];
  assign chan_block_func_sel  = cc_three_ff[e1cc_pkg::B3_CHAN_BLK_SEL];
  assign idle_reg_func_sel    = cc_three_ff[e1cc_pkg::B3_IDLE_REG_SEL];
  assign rx_sig_reinsert_en   = cc_three_ff[e1cc_pkg::B3_RX_SIG_REINS];
  assign tx_sig_reinsert_en   = cc_three_ff[e1cc_pkg::B3_TX_SIG_REINS];
  assign tx_backplane_clk_sel = cc_three_ff[e1cc_pkg::B3_TX_BPCLK_SEL];
  assign cpu_rdata            = rdata_ff;

  // control bits used by the data path
  wire       remote_loop_en         = cc_four_ff[e1cc_pkg::B4_REMOTE_LOOP];
  wire       local_loop_en          = cc_four_ff[e1cc_pkg::B4_LOCAL_LOOP];
  wire       line_ais_force         = cc_four_ff[e1cc_pkg::B4_LINE_AIS];
  wire       disconnect_pattern_gen = cc_six_ff[e1cc_pkg::B6_DISCONNECT];
  wire       carrier_loss_alt       = cc_three_ff[e1cc_pkg::B3_CARRIER_ALT];
  wire [4:0] tx_chan_monitor_sel    = cc_four_ff[e1cc_pkg::CHAN_MSB:0];
  wire [4:0] rx_chan_monitor_sel    = cc_five_ff[e1cc_pkg::CHAN_MSB:0];

  // crc4 multiframe search timer
  e1cc_crc_timer #(
    .LATE_CYC  (RAI_WAIT_CYC),
    .CONST_CYC (CONST_RAI_CYC)
  ) u_crc_timer (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .searching (crc4_en && fas_sync && !crc4_mf_sync),
    .late_ff   (late_w),
    .const_ff  (const_w)
  );

  // receive alarm conditions shared by ais and rai
  wire rx_alarm = rx_loss_sync || rx_ais_detect || rcl_ff;
  // crc4 late search adds a rai cause
  wire nxt_rai  = auto_rai_en && (rx_alarm || late_w || const_w);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ais_ff     <= 1'b0;
      rai_ff     <= 1'b0;
      clk_rec_ff <= 1'b0;
    end else begin
      ais_ff     <= auto_ais_en && rx_alarm;
      rai_ff     <= nxt_rai;
      clk_rec_ff <= cc_six_ff[e1cc_pkg::B6_TX_CLK_SRC]
                    || (tx_clock_fail_mux && tx_clock_stopped);
    end
  end

  // generated patterns: alternating marks for ones, mark-space for 1010
  wire       gen_mode = line_ais_force || disconnect_pattern_gen || (ais_ff && !remote_loop_en);
  wire [1:0] ones_w   = {~gen_cnt_ff[0], gen_cnt_ff[0]};
  wire [1:0] disc_w   = {~gen_cnt_ff[0] & ~gen_cnt_ff[1], ~gen_cnt_ff[0] & gen_cnt_ff[1]};

  assign buf_in.data =
    line_ais_force         ? ones_w :
    disconnect_pattern_gen ? disc_w :
    remote_loop_en         ? {rx_line_pos_in, rx_line_neg_in} :
    ais_ff                 ? ones_w : {tx_fmt_pos, tx_fmt_neg};
  assign buf_in.valid  = (remote_loop_en && !line_ais_force && !disconnect_pattern_gen)
                         ? rx_line_valid : tx_fmt_valid;
  assign buf_out.ready = tx_line_ready;
  assign tx_fmt_ready  = buf_in.ready;

  // line word buffer
  e1cc_skid2 u_skid (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .in_s    (buf_in),
    .out_s   (buf_out)
  );

  assign tx_line_valid   = buf_out.valid;
  assign tx_line_pos_out = buf_out.data[1];
  assign tx_line_neg_out = buf_out.data[0];

  wire gen_step = gen_mode && tx_fmt_valid && buf_in.ready;
  wire tx_pop   = buf_out.valid && tx_line_ready;

  // local loop feeds the framer with transmitted words
  wire nxt_fr_vld = local_loop_en ? tx_pop : rx_line_valid;
  wire nxt_fr_pos = local_loop_en ? buf_out.data[1] : rx_line_pos_in;
  wire nxt_fr_neg = local_loop_en ? buf_out.data[0] : rx_line_neg_in;

  wire [11:0] zero_thr = carrier_loss_alt ? e1cc_pkg::ZEROS_ALT : e1cc_pkg::ZEROS_STD;
  wire        fr_zero  = !fr_pos_ff && !fr_neg_ff;
  wire [11:0] nxt_zero =
    !fr_vld_ff ? zero_cnt_ff :
    !fr_zero   ? 12'h000 :
    (zero_cnt_ff >= zero_thr) ? zero_thr : zero_cnt_ff + 12'h001;

  // receive path register, carrier loss and pattern phase
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fr_vld_ff   <= 1'b0;
      fr_pos_ff   <= 1'b0;
      fr_neg_ff   <= 1'b0;
      zero_cnt_ff <= 12'h000;
      rcl_ff      <= 1'b0;
      gen_cnt_ff  <= 2'h0;
    end else begin
      fr_vld_ff   <= nxt_fr_vld;
      fr_pos_ff   <= nxt_fr_pos;
      fr_neg_ff   <= nxt_fr_neg;
      zero_cnt_ff <= nxt_zero;
      rcl_ff      <= (nxt_zero >= zero_thr);
      if (gen_step) gen_cnt_ff <= gen_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_mon_ff <= 8'h00;
      rx_mon_ff <= 8'h00;
    end else begin
      if (chan_hit(tx_ts_valid, tx_ts_num, tx_chan_monitor_sel)) tx_mon_ff <= tx_ts_data;
      if (chan_hit(rx_ts_valid, rx_ts_num, rx_chan_monitor_sel)) rx_mon_ff <= rx_ts_data;
    end
  end

  assign rx_fr_valid          = fr_vld_ff;
  assign rx_fr_pos            = fr_pos_ff;
  assign rx_fr_neg            = fr_neg_ff;
  assign rx_carrier_loss      = rcl_ff;
  assign tx_ais_active        = ais_ff;
  assign tx_rai_active        = rai_ff;
  assign tx_rai_constant      = const_w;
  assign tx_clk_use_recovered = clk_rec_ff;
  assign rx_estore_align      = rx_align_ff;
  assign tx_estore_align      = tx_align_ff;
  assign rx_estore_reset      = rx_rst_ff;
  assign tx_estore_reset      = tx_rst_ff;
  assign tx_chan_monitor_reg  = tx_mon_ff;
  assign rx_chan_monitor_reg  = rx_mon_ff;

  // command write sequences
  sequence s_rx_align_rise;
    wr5 && cpu_wdata[e1cc_pkg::B5_RX_ALIGN] && !cc_five_ff[e1cc_pkg::B5_RX_ALIGN];
  endsequence
  sequence s_one_pulse(sig);
    sig ##1 !sig;
  endsequence

  a_auto_ais_on: assert property (@(posedge sys_clk) disable iff (!nrst)
    (auto_ais_en && (rx_loss_sync || rx_ais_detect)) |=> tx_ais_active)
    else $error("automatic ais not raised");
  a_rai_late: assert property (@(posedge sys_clk) disable iff (!nrst)
    (auto_rai_en && late_w) |-> ##DLY_ONE tx_rai_active)
    else $error("rai missing after late crc4 search");
  a_rai_constant: assert property (@(posedge sys_clk) disable iff (!nrst)
    (tx_rai_constant && auto_rai_en) |=> tx_rai_active)
    else $error("constant rai not sent");
  a_ais_release: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!auto_ais_en || !(rx_loss_sync || rx_ais_detect || rcl_ff)) |=> !tx_ais_active)
    else $error("ais held without cause");
  a_carrier_std: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!carrier_loss_alt && fr_vld_ff && fr_zero && zero_cnt_ff == 12'h0FE) |=> rx_carrier_loss)
    else $error("carrier loss late at 255 zeros");
  a_align_once: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_rx_align_rise |=> s_one_pulse(rx_estore_align))
    else $error("align pulse wrong");
  a_reset_edge: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr6 && cpu_wdata[e1cc_pkg::B6_TX_ES_RESET] && !cc_six_ff[e1cc_pkg::B6_TX_ES_RESET])
      |-> ##DLY_ONE tx_estore_reset ##DLY_ONE !tx_estore_reset)
    else $error("reset pulse wrong");
  a_clk_source: assert property (@(posedge sys_clk) disable iff (!nrst)
    cc_six_ff[e1cc_pkg::B6_TX_CLK_SRC] |=> tx_clk_use_recovered)
    else $error("recovered clock not forced");
  a_local_loop: assert property (@(posedge sys_clk) disable iff (!nrst)
    (local_loop_en && tx_pop) |=> rx_fr_valid && rx_fr_pos == $past(tx_line_pos_out))
    else $error("local loop data mismatch");
  a_remote_loop: assert property (@(posedge sys_clk) disable iff (!nrst)
    (remote_loop_en && !line_ais_force && !disconnect_pattern_gen && rx_line_valid
      && !buf_out.valid) |-> ##DLY_ONE
      (tx_line_valid && tx_line_neg_out == $past(rx_line_neg_in)))
    else $error("remote loop data mismatch");
  a_line_ais_ones: assert property (@(posedge sys_clk) disable iff (!nrst)
    (line_ais_force && tx_fmt_valid && !buf_out.valid) |-> ##DLY_ONE
      (tx_line_valid && (tx_line_pos_out ^ tx_line_neg_out)))
    else $error("line ais not all ones");
endmodule : e1cc_common_ctrl

// ===== verification/e1cc_line_model.sv
// line-side partner: takes transmit line words, can stall
`timescale 1ns/100ps
module e1cc_line_model (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       stall,
  input  wire logic       tx_line_valid,
  input  wire logic       tx_line_pos_out,
  input  wire logic       tx_line_neg_out,
  output logic            tx_line_ready,
  output logic      [7:0] words,
  output logic      [7:0] marks
);
  // ready drops while stalled so the buffer must hold its words
  assign tx_line_ready = !stall;
  // count taken words and the ones that carry a mark
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      words <= 8'h00;
      marks <= 8'h00;
    end else if (tx_line_valid && tx_line_ready) begin
      words <= words + 8'h01;
      marks <= marks + {7'h00, tx_line_pos_out | tx_line_neg_out};
    end
  end
endmodule : e1cc_line_model

// ===== verification/e1_common_control_alarm_loopback_tb_top.sv
// self-checking bench for the e1 common control block
`timescale 1ns/100ps
module e1_common_control_alarm_loopback_tb_top;
  logic sys_clk = 1'b0, nrst = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, stall = 1'b0;
  logic auto_ais_en = 1'b0, auto_rai_en = 1'b0, crc4_en = 1'b0, fas_sync = 1'b0;
  logic rx_loss_sync = 1'b0, rx_ais_detect = 1'b0, crc4_mf_sync = 1'b0, tx_ts_valid = 1'b0;
  logic tx_clock_fail_mux = 1'b0, tx_clock_stopped = 1'b0, rx_ts_valid = 1'b0;
  logic tx_fmt_valid = 1'b0, tx_fmt_pos = 1'b0, tx_fmt_neg = 1'b0;
  logic rx_line_valid = 1'b0, rx_line_pos_in = 1'b0, rx_line_neg_in = 1'b0;
  logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, tx_ts_data = 8'h00, rx_ts_data = 8'h00;
  logic [4:0] tx_ts_num = 5'h00, rx_ts_num = 5'h00;
  logic [7:0] cpu_rdata, tx_chan_monitor_reg, rx_chan_monitor_reg, words, marks, w0;
  logic tx_fmt_ready, tx_line_valid, tx_line_ready, tx_line_pos_out, tx_line_neg_out;
  logic rx_fr_valid, rx_fr_pos, rx_fr_neg, rx_carrier_loss, tx_ais_active, tx_rai_active;
  logic tx_rai_constant, tx_estore_enable, chan_block_func_sel, idle_reg_func_sel;
  logic rx_sig_reinsert_en, tx_sig_reinsert_en, tx_backplane_clk_sel, tx_clk_use_recovered;
  logic rx_estore_align, tx_estore_align, rx_estore_reset, tx_estore_reset;
  logic [3:0] pl;
  int errors = 0, checked = 0;
  e1cc_common_ctrl #(.RAI_WAIT_CYC(20), .CONST_RAI_CYC(50)) DUT (.*);
  e1cc_line_model u_line (.*);
  // 4 ns clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic cmp(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // one register write; snapshot of the command pulses after it lands
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge sys_clk);
    cpu_wr <= 1'b0;
    #1 pl = {rx_estore_align, tx_estore_align, rx_estore_reset, tx_estore_reset};
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
    #1 cmp("cpu_rdata", {4'h0, exp}, {4'h0, cpu_rdata});
  endtask : rd
  // one beat: {fmt valid, pos, neg, rx valid, pos, neg}
  task automatic beat(input logic [5:0] b);
    @(posedge sys_clk);
    {tx_fmt_valid, tx_fmt_pos, tx_fmt_neg, rx_line_valid, rx_line_pos_in, rx_line_neg_in} <= b;
    @(posedge sys_clk);
    {tx_fmt_valid, rx_line_valid} <= 2'b00;
  endtask : beat
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(e1cc_pkg::CC_THREE_ADDR, 8'h00);
    rd(e1cc_pkg::CC_FOUR_ADDR, 8'h00);
    // zero run on the receive line
    @(posedge sys_clk);
    rx_line_valid <= 1'b1;
    tick(250);
    cmp("carrier", 0, rx_carrier_loss);
    tick(12);
    cmp("carrier", 1, rx_carrier_loss);
    auto_ais_en <= 1'b1;
    tick(3);
    cmp("ais", 1, tx_ais_active);
    rx_line_pos_in <= 1'b1;
    tick(4);
    cmp("carrier ais", 0, {rx_carrier_loss, tx_ais_active});
    wr(e1cc_pkg::CC_THREE_ADDR, 8'h01);
    rx_line_pos_in <= 1'b0;
    tick(300);
    cmp("carrier alt", 0, rx_carrier_loss);
    rx_line_valid <= 1'b0;
    rx_loss_sync <= 1'b1;
    tick(4);
    cmp("ais sync", 1, tx_ais_active);
    {rx_loss_sync, rx_ais_detect, auto_rai_en} <= 3'b011;
    tick(3);
    cmp("ais rai", 3, {tx_ais_active, tx_rai_active});
    {rx_ais_detect, auto_ais_en, crc4_en, fas_sync} <= 4'b0011;
    tick(10);
    cmp("rai crc", 0, {tx_rai_active, tx_rai_constant});
    tick(20);
    cmp("rai crc", 2, {tx_rai_active, tx_rai_constant});
    tick(30);
    cmp("rai crc", 3, {tx_rai_active, tx_rai_constant});
    crc4_mf_sync <= 1'b1;
    tick(3);
    cmp("rai crc", 0, {tx_rai_active, tx_rai_constant});
    // control bits, with the unassigned bit written as zero
    wr(e1cc_pkg::CC_THREE_ADDR, 8'hEF);
    cmp("common_control_three bits", 12'h03F, {tx_estore_enable, chan_block_func_sel, idle_reg_func_sel,
        rx_sig_reinsert_en, tx_sig_reinsert_en, tx_backplane_clk_sel});
    rd(e1cc_pkg::CC_THREE_ADDR, 8'hEF);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h00);
    wr(e1cc_pkg::CC_FIVE_ADDR, 8'h7F);
    cmp("align", 12'hC, pl);
    wr(e1cc_pkg::CC_FIVE_ADDR, 8'h7F);
    cmp("align again", 0, pl);
    wr(e1cc_pkg::CC_SIX_ADDR, 8'hE7);
    cmp("es reset", 12'h3, pl);
    rd(e1cc_pkg::CC_SIX_ADDR, 8'hE7);
    tick(2);
    cmp("clk src", 1, tx_clk_use_recovered);
    wr(e1cc_pkg::CC_SIX_ADDR, 8'h00);
    {tx_clock_fail_mux, tx_clock_stopped} <= 2'b11;
    tick(3);
    cmp("clk fail", 1, tx_clk_use_recovered);
    tx_clock_stopped <= 1'b0;
    tick(3);
    cmp("clk fail", 0, tx_clk_use_recovered);
    // channel monitors: selected slot kept, neighbour ignored
    wr(e1cc_pkg::CC_FOUR_ADDR, 8'h05);
    @(posedge sys_clk);
    {tx_ts_valid, tx_ts_num, tx_ts_data, rx_ts_valid, rx_ts_num, rx_ts_data}
      <= {1'b1, 5'h05, 8'hA5, 1'b1, 5'h1F, 8'h5A};
    @(posedge sys_clk);
    {tx_ts_num, tx_ts_data, rx_ts_num, rx_ts_data} <= {5'h06, 8'h3C, 5'h1E, 8'hC3};
    @(posedge sys_clk);
    {tx_ts_valid, rx_ts_valid} <= 2'b00;
    tick(2);
    cmp("tx mon", 12'h0A5, {4'h0, tx_chan_monitor_reg});
    cmp("rx mon", 12'h05A, {4'h0, rx_chan_monitor_reg});
    // forced line patterns: all ones then 1010
    wr(e1cc_pkg::CC_FOUR_ADDR, 8'h20);
    w0 = marks;
    repeat (4) beat(6'b100000);
    tick(6);
    cmp("ais marks", 12'h004, {4'h0, marks - w0});
    wr(e1cc_pkg::CC_FOUR_ADDR, 8'h00);
    wr(e1cc_pkg::CC_SIX_ADDR, 8'h40);
    w0 = marks;
    repeat (4) beat(6'b100000);
    tick(6);
    cmp("1010 marks", 12'h002, {4'h0, marks - w0});
    wr(e1cc_pkg::CC_SIX_ADDR, 8'h00);
    // remote loop: space words from the line replace formatter marks
    wr(e1cc_pkg::CC_FOUR_ADDR, 8'h80);
    {w0, pl} = {marks, words[3:0]};
    repeat (3) beat(6'b110100);
    tick(6);
    cmp("rloop", 12'h003, {marks - w0, words[3:0] - pl});
    wr(e1cc_pkg::CC_FOUR_ADDR, 8'h40);
    beat(6'b110000);
    for (int i = 0; i < 8 && rx_fr_valid !== 1'b1; i++) tick(1);
    cmp("lloop", 12'h006, {rx_fr_valid, rx_fr_pos, rx_fr_neg});
    // stalled receiver: buffer holds two words, refuses the third
    wr(e1cc_pkg::CC_FOUR_ADDR, 8'h00);
    stall <= 1'b1;
    w0 = words;
    repeat (3) beat(6'b110000);
    tick(1);
    cmp("fmt ready", 0, tx_fmt_ready);
    stall <= 1'b0;
    tick(6);
    cmp("drained", 12'h002, {4'h0, words - w0});
    complete_run();
  end
endmodule : e1_common_control_alarm_loopback_tb_top
